// ---- sreg_pkg.sv ----
// constants and types for the interrupt, timer and save special-register bank
// Operation
// R1 - level-one scratch register stores written value and returns it on read
// R2 - one scratch register per higher level; reads beyond the total are undefined
// R3 - memory-error scratch register, written and read with no side effect
// R4 - pending word follows interrupt inputs, reads zero-extended, no exchange
// R5 - set view ORs written low bits into pending, software bits only
// R6 - clear view clears pending bits written as one, clearable bits only
// R7 - set-view interrupt is visible before a following memory sync completes
// R8 - enable mask stores low bits, reads zero-extended, allows exchange
// R9 - instruction counter increments, raises debug exception, access gated by level
// R10 - count level holds four low bits, reads back zero-extended
// R11 - new count level is honoured from the next instruction after a write
// R12 - cycle counter increments every clock and is readable and writable
// R13 - software normally leaves the cycle counter unwritten
// R14 - compare write stores value and clears that compare's timer pending bit
// R15 - timer pending bit set when cycle counter equals the compare value
// R16 - breakpoint enable mask holds one bit per breakpoint, read zero-extended
package sreg_pkg;
	localparam int IRQ_LINES = 32;
	localparam int IRQ_LEVELS = 6;
	localparam int NMI_LEVELS = 1;
	localparam int HIGH_SAVES = IRQ_LEVELS + NMI_LEVELS - 1;
	localparam int COMPARES = 3;
	localparam int IBREAKS = 2;
	localparam int INSN_COUNTER_W = 32;
	localparam logic [7:0] SR_IBREAK_EN = 8'h60;
	localparam logic [7:0] SR_MEM_SAVE = 8'h6C;
	localparam logic [7:0] SR_SAVE1 = 8'hC0;
	localparam logic [7:0] SR_SAVE_HI = 8'hD0;
	localparam logic [7:0] SR_PENDING = 8'hE2;
	localparam logic [7:0] SR_CLEAR = 8'hE3;
	localparam logic [7:0] SR_ENABLE = 8'hE4;
	localparam logic [7:0] SR_CYCLES = 8'hEA;
	localparam logic [7:0] SR_INSN_COUNTER = 8'hEC;
	localparam logic [7:0] SR_INSN_COUNTER_LVL = 8'hED;
	localparam logic [7:0] SR_COMPARE = 8'hF0;
	localparam logic [31:0] SW_IRQ_MASK = 32'h0000_0180;
	localparam logic [31:0] CLR_IRQ_MASK = 32'h0000_01C0;
	localparam logic [31:0] EXT_IRQ_MASK = 32'hFFFF_FE3F;
	localparam logic [4:0] TIMER_BIT0 = 5'h06;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [3:0] LEVEL_RESET = 4'h0;
	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_WRITE = 2'b01,
		OP_XCHG = 2'b10,
		OP_NONE = 2'b11
	} sr_op_t;
endpackage

// ---- sreg_bank.sv ----
// special-register bank: save scratch, interrupt pending/enable, counters, compares
module sreg_bank (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_sr_valid,
	input wire sreg_pkg::sr_op_t i_sr_op,
	input wire logic [7:0] i_sr_num,
	input wire logic [31:0] i_sr_wdata,
	input wire logic [3:0] i_cur_irq_level,
	input wire logic i_insn_retire,
	input wire logic [31:0] i_irq_lines,
	output logic [31:0] o_sr_rdata,
	output logic o_sr_illegal,
	output logic [31:0] o_irq_pending,
	output logic [31:0] o_irq_enable,
	output logic o_irq_take,
	output logic o_insn_counter_debug,
	output logic [1:0] o_ibreak_enable
);
	import sreg_pkg::*;

	logic [31:0] save1_r, save1_nxt;
	logic [31:0] save_hi_r [HIGH_SAVES];
	logic [31:0] save_hi_nxt [HIGH_SAVES];
	logic [31:0] memsave_r, memsave_nxt;
	logic [31:0] pend_r, pend_nxt;
	logic [31:0] enable_r, enable_nxt;
	logic [31:0] cycles_r, cycles_nxt;
	logic [31:0] insn_counter_r, insn_counter_nxt;
	logic [3:0] insn_counter_lvl_r, insn_counter_lvl_nxt;
	logic [31:0] compare_r [COMPARES];
	logic [31:0] compare_nxt [COMPARES];
	logic [1:0] ibreak_r, ibreak_nxt;
	logic [31:0] rdata_nxt;
	logic illegal_nxt, take_nxt, dbg_nxt;
	logic wr, rd, insn_counter_ok;
	logic [31:0] timer_hit, timer_clr;

	assign wr = i_sr_valid && (i_sr_op == OP_WRITE || i_sr_op == OP_XCHG);
	assign rd = i_sr_valid && (i_sr_op == OP_READ || i_sr_op == OP_XCHG);
	assign insn_counter_ok = i_cur_irq_level >= insn_counter_lvl_r; // R9 R11

	// per-compare match and write-clear of the timer pending bit
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_timer
			if (g >= TIMER_BIT0 && g < TIMER_BIT0 + COMPARES) begin : g_on
				assign timer_hit[g] = cycles_r == compare_r[g - TIMER_BIT0]; // R15
				assign timer_clr[g] = wr && i_sr_num == SR_COMPARE + 8'(g - TIMER_BIT0); // R14
			end else begin : g_off
				assign timer_hit[g] = 1'b0;
				assign timer_clr[g] = 1'b0;
			end
		end
	endgenerate

	always_comb begin
		save1_nxt = save1_r;
		save_hi_nxt = save_hi_r;
		memsave_nxt = memsave_r;
		enable_nxt = enable_r;
		compare_nxt = compare_r;
		ibreak_nxt = ibreak_r;
		insn_counter_lvl_nxt = insn_counter_lvl_r;
		cycles_nxt = cycles_r + 32'h0000_0001; // R12
		insn_counter_nxt = insn_counter_r;
		if (i_insn_retire && insn_counter_ok) begin
			insn_counter_nxt = insn_counter_r + 32'h0000_0001; // R9
		end
		// hardware events win over software clears in the same cycle
		pend_nxt = pend_r;
		if (wr && i_sr_op == OP_WRITE && i_sr_num == SR_CLEAR) begin
			pend_nxt = pend_nxt & ~(i_sr_wdata & CLR_IRQ_MASK); // R6
		end
		pend_nxt = pend_nxt & ~timer_clr; // R14
		if (wr && i_sr_op == OP_WRITE && i_sr_num == SR_PENDING) begin
			pend_nxt = pend_nxt | (i_sr_wdata & SW_IRQ_MASK); // R5 R7
		end
		pend_nxt = (pend_nxt & ~EXT_IRQ_MASK) | (i_irq_lines & EXT_IRQ_MASK); // R4
		pend_nxt = pend_nxt | timer_hit; // R15
		if (wr) begin
			if (i_sr_num == SR_SAVE1) begin
				save1_nxt = i_sr_wdata; // R1
			end else if (i_sr_num >= SR_SAVE_HI + 8'h02 && i_sr_num < SR_SAVE_HI + 8'(HIGH_SAVES + 2)) begin
				save_hi_nxt[i_sr_num[2:0] - 3'h2] = i_sr_wdata; // R2
			end else if (i_sr_num == SR_MEM_SAVE) begin
				memsave_nxt = i_sr_wdata; // R3
			end else if (i_sr_num == SR_ENABLE) begin
				enable_nxt = i_sr_wdata; // R8
			end else if (i_sr_num == SR_CYCLES) begin
				cycles_nxt = i_sr_wdata; // R12
			end else if (i_sr_num == SR_INSN_COUNTER && insn_counter_ok) begin
				insn_counter_nxt = i_sr_wdata; // R9
			end else if (i_sr_num == SR_INSN_COUNTER_LVL) begin
				insn_counter_lvl_nxt = i_sr_wdata[3:0]; // R10
			end else if (i_sr_num == SR_IBREAK_EN) begin
				ibreak_nxt = i_sr_wdata[1:0]; // R16
			end else if (i_sr_num >= SR_COMPARE && i_sr_num < SR_COMPARE + 8'(COMPARES)) begin
				compare_nxt[i_sr_num[1:0]] = i_sr_wdata; // R14
			end
		end
		// exchange of pending or clear views is not legal
		illegal_nxt = i_sr_valid && i_sr_op == OP_XCHG && (i_sr_num == SR_PENDING || i_sr_num == SR_CLEAR); // R4
		rdata_nxt = 32'h0000_0000;
		if (rd) begin
			if (i_sr_num == SR_SAVE1) begin
				rdata_nxt = save1_r; // R1
			end else if (i_sr_num >= SR_SAVE_HI + 8'h02 && i_sr_num < SR_SAVE_HI + 8'(HIGH_SAVES + 2)) begin
				rdata_nxt = save_hi_r[i_sr_num[2:0] - 3'h2]; // R2
			end else if (i_sr_num == SR_MEM_SAVE) begin
				rdata_nxt = memsave_r; // R3
			end else if (i_sr_num == SR_PENDING) begin
				rdata_nxt = pend_r; // R4
			end else if (i_sr_num == SR_ENABLE) begin
				rdata_nxt = enable_r; // R8
			end else if (i_sr_num == SR_CYCLES) begin
				rdata_nxt = cycles_r; // R12
			end else if (i_sr_num == SR_INSN_COUNTER && insn_counter_ok) begin
				rdata_nxt = insn_counter_r; // R9
			end else if (i_sr_num == SR_INSN_COUNTER_LVL) begin
				rdata_nxt = {28'h000_0000, insn_counter_lvl_r}; // R10
			end else if (i_sr_num == SR_IBREAK_EN) begin
				rdata_nxt = {30'h0, ibreak_r}; // R16
			end else if (i_sr_num >= SR_COMPARE && i_sr_num < SR_COMPARE + 8'(COMPARES)) begin
				rdata_nxt = compare_r[i_sr_num[1:0]]; // R14
			end
		end
		take_nxt = |(pend_nxt & enable_nxt); // R8
		// debug exception when the counter wraps to zero while counting is enabled
		dbg_nxt = i_insn_retire && insn_counter_ok && insn_counter_r == 32'hFFFF_FFFF; // R9
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			save1_r <= WORD_RESET;
			save_hi_r <= '{default: WORD_RESET};
			memsave_r <= WORD_RESET;
			pend_r <= WORD_RESET;
			enable_r <= WORD_RESET;
			cycles_r <= WORD_RESET;
			insn_counter_r <= WORD_RESET;
			insn_counter_lvl_r <= LEVEL_RESET;
			compare_r <= '{default: WORD_RESET};
			ibreak_r <= 2'h0;
			o_sr_rdata <= WORD_RESET;
			o_sr_illegal <= 1'b0;
			o_irq_pending <= WORD_RESET;
			o_irq_enable <= WORD_RESET;
			o_irq_take <= 1'b0;
			o_insn_counter_debug <= 1'b0;
			o_ibreak_enable <= 2'h0;
		end else begin
			save1_r <= save1_nxt;
			save_hi_r <= save_hi_nxt;
			memsave_r <= memsave_nxt;
			pend_r <= pend_nxt;
			enable_r <= enable_nxt;
			cycles_r <= cycles_nxt;
			insn_counter_r <= insn_counter_nxt;
			insn_counter_lvl_r <= insn_counter_lvl_nxt;
			compare_r <= compare_nxt;
			ibreak_r <= ibreak_nxt;
			o_sr_rdata <= rdata_nxt;
			o_sr_illegal <= illegal_nxt;
			o_irq_pending <= pend_nxt;
			o_irq_enable <= enable_nxt;
			o_irq_take <= take_nxt;
			o_insn_counter_debug <= dbg_nxt;
			o_ibreak_enable <= ibreak_nxt;
		end
	end

	// set-view write is seen on the pending output the next cycle
	property p_set_visible;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_PENDING && i_sr_wdata[7]) |=> o_irq_pending[7];
	endproperty
	a_set_visible: assert property (p_set_visible) else $error("set view bit not pending"); // R5

	property p_clear_works;
		@(posedge i_clk) disable iff (!i_reset_n)
		// a same-cycle match of the third compare wins over the clear
		(i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_CLEAR && i_sr_wdata[8]
			&& cycles_r != compare_r[2]) |=> !o_irq_pending[8];
	endproperty
	a_clear_works: assert property (p_clear_works) else $error("clear view did not clear"); // R6

	// sampled reset keeps the release edge, where the counter still reads zero, out of the check
	property p_cycle_inc;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_reset_n && !(i_sr_valid && i_sr_num == SR_CYCLES && i_sr_op != OP_READ)
			|=> cycles_r == $past(cycles_r) + 32'h0000_0001;
	endproperty
	a_cycle_inc: assert property (p_cycle_inc) else $error("cycle counter missed increment"); // R12

	property p_timer_set;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_reset_n && cycles_r == compare_r[0] |=> o_irq_pending[TIMER_BIT0];
	endproperty
	a_timer_set: assert property (p_timer_set) else $error("timer match not pending"); // R15

	sequence s_enable_write;
		i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_ENABLE;
	endsequence
	property p_enable_store;
		@(posedge i_clk) disable iff (!i_reset_n)
		s_enable_write |=> o_irq_enable == $past(i_sr_wdata);
	endproperty
	a_enable_store: assert property (p_enable_store) else $error("enable mask not stored"); // R8

	property p_level_read;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_sr_valid && i_sr_op == OP_READ && i_sr_num == SR_INSN_COUNTER_LVL) |=> o_sr_rdata[31:4] == 28'h000_0000;
	endproperty
	a_level_read: assert property (p_level_read) else $error("count level not zero-extended"); // R10

	property p_xchg_illegal;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_sr_valid && i_sr_op == OP_XCHG && i_sr_num == SR_PENDING) |=> o_sr_illegal;
	endproperty
	a_xchg_illegal: assert property (p_xchg_illegal) else $error("exchange of pending not flagged"); // R4

	property p_ibreak;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_IBREAK_EN) |=> o_ibreak_enable == $past(i_sr_wdata[1:0]);
	endproperty
	a_ibreak: assert property (p_ibreak) else $error("breakpoint enable not stored"); // R16

	// scratch echo: a write, one idle cycle, then a read of the same register
	sequence s_save1_wr;
		i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_SAVE1;
	endsequence
	sequence s_save1_rd;
		i_sr_valid && i_sr_op == OP_READ && i_sr_num == SR_SAVE1;
	endsequence
	property p_save1_echo;
		@(posedge i_clk) disable iff (!i_reset_n)
		s_save1_wr ##1 !i_sr_valid ##1 s_save1_rd |=> o_sr_rdata == $past(i_sr_wdata, 3);
	endproperty
	a_save1_echo: assert property (p_save1_echo) else $error("level-one scratch lost its value"); // R1

	sequence s_save_hi_wr;
		i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_SAVE_HI + 8'h02;
	endsequence
	sequence s_save_hi_rd;
		i_sr_valid && i_sr_op == OP_READ && i_sr_num == SR_SAVE_HI + 8'h02;
	endsequence
	property p_save_hi_echo;
		@(posedge i_clk) disable iff (!i_reset_n)
		s_save_hi_wr ##1 !i_sr_valid ##1 s_save_hi_rd |=> o_sr_rdata == $past(i_sr_wdata, 3);
	endproperty
	a_save_hi_echo: assert property (p_save_hi_echo) else $error("high-level scratch lost its value"); // R2

	sequence s_mem_wr;
		i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_MEM_SAVE;
	endsequence
	sequence s_mem_rd;
		i_sr_valid && i_sr_op == OP_READ && i_sr_num == SR_MEM_SAVE;
	endsequence
	property p_mem_echo;
		@(posedge i_clk) disable iff (!i_reset_n)
		s_mem_wr ##1 !i_sr_valid ##1 s_mem_rd |=> o_sr_rdata == $past(i_sr_wdata, 3);
	endproperty
	a_mem_echo: assert property (p_mem_echo) else $error("memory-error scratch lost its value"); // R3

	sequence s_lvl_wr;
		i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_INSN_COUNTER_LVL;
	endsequence
	sequence s_lvl_rd;
		i_sr_valid && i_sr_op == OP_READ && i_sr_num == SR_INSN_COUNTER_LVL;
	endsequence
	property p_lvl_echo;
		@(posedge i_clk) disable iff (!i_reset_n)
		s_lvl_wr ##1 !i_sr_valid ##1 s_lvl_rd |=> o_sr_rdata == {28'h000_0000, $past(i_sr_wdata[3:0], 3)};
	endproperty
	a_lvl_echo: assert property (p_lvl_echo) else $error("count level lost its value"); // R10

	// compare write drops its timer bit unless the counter matches that same cycle
	sequence s_cmp1_wr;
		i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_COMPARE + 8'h01 && cycles_r != compare_r[1];
	endsequence
	property p_cmp_clear;
		@(posedge i_clk) disable iff (!i_reset_n)
		s_cmp1_wr |=> !o_irq_pending[TIMER_BIT0 + 5'h01];
	endproperty
	a_cmp_clear: assert property (p_cmp_clear) else $error("compare write left timer pending"); // R14

	property p_timer_set1;
		@(posedge i_clk) disable iff (!i_reset_n)
		i_reset_n && cycles_r == compare_r[1] |=> o_irq_pending[TIMER_BIT0 + 5'h01];
	endproperty
	a_timer_set1: assert property (p_timer_set1) else $error("second timer match not pending"); // R15

	// a refused counter write leaves the count alone, retire pulses included
	property p_insn_counter_gate;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_INSN_COUNTER && i_cur_irq_level < insn_counter_lvl_r)
			|=> insn_counter_r == $past(insn_counter_r);
	endproperty
	a_insn_counter_gate: assert property (p_insn_counter_gate) else $error("counter write taken below threshold"); // R9

	sequence s_insn_counter_last;
		i_insn_retire && i_cur_irq_level >= insn_counter_lvl_r && insn_counter_r == 32'hFFFF_FFFF
			&& !(i_sr_valid && i_sr_num == SR_INSN_COUNTER);
	endsequence
	property p_insn_counter_wrap;
		@(posedge i_clk) disable iff (!i_reset_n)
		s_insn_counter_last |=> o_insn_counter_debug && insn_counter_r == 32'h0000_0000;
	endproperty
	a_insn_counter_wrap: assert property (p_insn_counter_wrap) else $error("counter wrap raised no debug event"); // R9

	property p_xchg_clear;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_sr_valid && i_sr_op == OP_XCHG && i_sr_num == SR_CLEAR) |=> o_sr_illegal;
	endproperty
	a_xchg_clear: assert property (p_xchg_clear) else $error("exchange of clear view not flagged"); // R4

	// a set-view write cannot raise a timer-only bit
	property p_set_sw_only;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_sr_valid && i_sr_op == OP_WRITE && i_sr_num == SR_PENDING && !pend_r[TIMER_BIT0] && cycles_r != compare_r[0])
			|=> !o_irq_pending[TIMER_BIT0];
	endproperty
	a_set_sw_only: assert property (p_set_sw_only) else $error("set view raised a timer bit"); // R5

	property p_ibreak_read;
		@(posedge i_clk) disable iff (!i_reset_n)
		(i_sr_valid && i_sr_op == OP_READ && i_sr_num == SR_IBREAK_EN) |=> o_sr_rdata[31:2] == 30'h0;
	endproperty
	a_ibreak_read: assert property (p_ibreak_read) else $error("breakpoint enable not zero-extended"); // R16
endmodule

// ---- sreg_core_model.sv ----
// pipeline-side model that issues special-register accesses and retire pulses
module sreg_core_model (
	input wire logic i_clk,
	input wire logic [31:0] i_rdata,
	output logic o_valid,
	output sreg_pkg::sr_op_t o_op,
	output logic [7:0] o_num,
	output logic [31:0] o_wdata,
	output logic o_retire
);
	timeunit 1ns;
	timeprecision 1ns;
	import sreg_pkg::*;
	initial begin
		o_valid = 1'b0;
		o_op = OP_NONE;
		o_num = 8'h00;
		o_wdata = 32'h0000_0000;
		o_retire = 1'b0;
	end
	// the cycle counter is never written from here, only read
	task automatic acc(input sr_op_t op, input logic [7:0] num, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_op <= op;
		o_num <= num;
		o_wdata <= wd;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_op <= OP_NONE;
		o_num <= ~num;
		// released data shows the inverse, not a stale copy
		o_wdata <= ~wd;
		@(negedge i_clk);
		rd = i_rdata;
	endtask
	task automatic retire_one();
		@(posedge i_clk);
		o_retire <= 1'b1;
		@(posedge i_clk);
		o_retire <= 1'b0;
	endtask
endmodule

// ---- cpu_irq_timer_save_regs_tb_top.sv ----
// self-checking bench for the special-register bank
module cpu_irq_timer_save_regs_tb_top import sreg_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk, i_reset_n, valid, retire, illegal, take, dbg, seen;
	sr_op_t op;
	logic [7:0] num;
	logic [3:0] level;
	logic [1:0] ibrk;
	logic [31:0] wdata, rdata, pending, enable, lines, seed, rd, c1, c2, w, exp_p;
	logic [31:0] scr[$];
	logic [7:0] nums[$];
	int n_fail, comparisons;
	sreg_bank u_sreg_bank (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sr_valid(valid), .i_sr_op(op),
		.i_sr_num(num), .i_sr_wdata(wdata), .i_cur_irq_level(level), .i_insn_retire(retire),
		.i_irq_lines(lines), .o_sr_rdata(rdata), .o_sr_illegal(illegal), .o_irq_pending(pending),
		.o_irq_enable(enable), .o_irq_take(take), .o_insn_counter_debug(dbg), .o_ibreak_enable(ibrk));
	sreg_core_model u_core (.i_clk(i_clk), .i_rdata(rdata), .o_valid(valid), .o_op(op), .o_num(num),
		.o_wdata(wdata), .o_retire(retire));
	function automatic logic [31:0] nxt_rand();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	initial begin
		repeat (5000) @(posedge i_clk);
		n_fail++;
		close_out();
	end
	initial begin
		i_reset_n = 1'b0;
		level = 4'h0;
		lines = 32'h0000_0000;
		seed = 32'h0001_2CC4;
		repeat (10) @(posedge i_clk);
		i_reset_n <= 1'b1;
		// park compares far away; reset-time zero match would leave timers pending
		for (int i = 0; i < COMPARES; i++) u_core.acc(OP_WRITE, SR_COMPARE + i[7:0], 32'hFFFF_0000, rd);
		for (int i = 0; i < COMPARES; i++) begin
			u_core.acc(OP_READ, SR_COMPARE + i[7:0], 32'h0, rd);
			chk(rd, 32'hFFFF_0000);
		end
		chk(pending, 32'h0000_0000);
		nums = {SR_SAVE1, SR_MEM_SAVE};
		for (int i = 2; i < 2 + HIGH_SAVES; i++) nums.push_back(SR_SAVE_HI + i[7:0]);
		foreach (nums[i]) begin
			scr.push_back(nxt_rand());
			u_core.acc(OP_WRITE, nums[i], scr[i], rd);
			u_core.acc(OP_READ, nums[i], 32'h0, rd);
			chk(rd, scr[i]);
		end
		foreach (nums[i]) begin
			u_core.acc(OP_READ, nums[i], 32'h0, rd);
			chk(rd, scr[i]);
		end
		w = nxt_rand();
		u_core.acc(OP_WRITE, SR_ENABLE, w, rd);
		chk(enable, w);
		u_core.acc(OP_XCHG, SR_ENABLE, ~w, rd);
		chk(rd, w);
		chk(enable, ~w);
		@(posedge i_clk);
		lines <= nxt_rand();
		repeat (3) @(posedge i_clk);
		exp_p = (lines & EXT_IRQ_MASK) | SW_IRQ_MASK;
		u_core.acc(OP_WRITE, SR_PENDING, 32'hFFFF_FFFF, rd);
		chk(pending, exp_p);
		chk(take, |(exp_p & ~w));
		u_core.acc(OP_READ, SR_PENDING, 32'h0, rd);
		chk(rd, exp_p);
		chk(illegal, 1'b0);
		u_core.acc(OP_XCHG, SR_PENDING, 32'h0, rd);
		chk(illegal, 1'b1);
		u_core.acc(OP_XCHG, SR_CLEAR, 32'hFFFF_FFFF, rd);
		chk(illegal, 1'b1);
		chk(pending, exp_p);
		u_core.acc(OP_WRITE, SR_CLEAR, 32'hFFFF_FFFF, rd);
		chk(pending, lines & EXT_IRQ_MASK);
		u_core.acc(OP_READ, SR_CYCLES, 32'h0, c1);
		repeat (10) @(posedge i_clk);
		u_core.acc(OP_READ, SR_CYCLES, 32'h0, c2);
		chk(c2 - c1, 32'h0000_000C);
		u_core.acc(OP_WRITE, SR_COMPARE + 8'h01, c2 + 32'h0000_0028, rd);
		for (int k = 0; k < 80 && pending[7] !== 1'b1; k++) @(negedge i_clk);
		chk(pending[7], 1'b1);
		u_core.acc(OP_WRITE, SR_COMPARE + 8'h01, c2, rd);
		chk(pending[7], 1'b0);
		u_core.acc(OP_WRITE, SR_INSN_COUNTER_LVL, 32'h0000_0005, rd);
		u_core.acc(OP_READ, SR_INSN_COUNTER_LVL, 32'h0, rd);
		chk(rd, 32'h0000_0005);
		@(posedge i_clk);
		level <= 4'h3;
		// below threshold: write dropped, read gives zero
		u_core.acc(OP_WRITE, SR_INSN_COUNTER, 32'h0000_1234, rd);
		u_core.acc(OP_READ, SR_INSN_COUNTER, 32'h0, rd);
		chk(rd, 32'h0000_0000);
		@(posedge i_clk);
		level <= 4'h7;
		u_core.acc(OP_WRITE, SR_INSN_COUNTER, 32'hFFFF_FFFE, rd);
		u_core.retire_one();
		u_core.acc(OP_READ, SR_INSN_COUNTER, 32'h0, rd);
		chk(rd, 32'hFFFF_FFFF);
		seen = 1'b0;
		u_core.retire_one();
		repeat (3) begin
			@(negedge i_clk);
			seen = seen | (dbg === 1'b1);
		end
		chk(seen, 1'b1);
		u_core.acc(OP_WRITE, SR_IBREAK_EN, 32'h0000_0002, rd);
		chk(ibrk, 2'h2);
		u_core.acc(OP_READ, SR_IBREAK_EN, 32'h0, rd);
		chk(rd, 32'h0000_0002);
		u_core.acc(OP_READ, 8'h01, 32'h0, rd);
		chk(rd, 32'h0000_0000);
		close_out();
	end
endmodule
